// File: eeprom_pkg.sv
/*
 Shared constants and types of the serial EEPROM program/erase core:
 array geometry, instruction encodings, reset values and self-timer length.
 Assumes a 10 MHz core clock.
*/
package eeprom_pkg;

	// Core clock and self-timed cycle length
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_NS = 5000000;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

	// Array geometry
	localparam int WORDS = 64;
	localparam int WORD_W = 16;
	localparam int INDEX_W = 6;
	localparam int ADDR_W = 7;
	localparam logic [4:0] ADDR_BITS_X16 = 5'h06;
	localparam logic [4:0] ADDR_BITS_X8 = 5'h07;
	localparam logic [4:0] DATA_BITS_X16 = 5'h10;
	localparam logic [4:0] DATA_BITS_X8 = 5'h08;
	localparam logic [4:0] OPCODE_BITS = 5'h02;

	// Opcodes and special sub-codes
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_SPECIAL = 2'h0;
	localparam logic [1:0] SUB_ENABLE = 2'h3;
	localparam logic [1:0] SUB_DISABLE = 2'h0;
	localparam logic [1:0] SUB_CLEAR_ALL = 2'h2;
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1;

	// Reset values
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic PERMIT_RESET = 1'b0;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_OPCODE = 8'h02,
		ST_ADDR = 8'h04,
		ST_DATA = 8'h08,
		ST_ARMED = 8'h10,
		ST_READ = 8'h20,
		ST_BUSY = 8'h40,
		ST_SKIP = 8'h80
	} state_e;

	typedef enum logic [1:0] {
		PEND_WRITE = 2'h0,
		PEND_ERASE = 2'h1,
		PEND_CLEAR_ALL = 2'h2,
		PEND_WRITE_ALL = 2'h3
	} pend_e;

endpackage

// File: serial_pin_edges.sv
/*
 Edge detection on the serial clock and select pins.
 Assumes both pins are already synchronous to the core clock.
*/
`timescale 1ns/1ps
module serial_pin_edges (
	// Core
	input wire logic clock,
	input wire logic rst_n,
	// Pins
	input wire logic serialClockIn,
	input wire logic deviceSelect,
	// Events
	output logic clockRise,
	output logic clockFall,
	output logic selectFall
);

	logic sckPrev_q;
	logic sckPrev_d;
	logic selPrev_q;
	logic selPrev_d;

	always_comb
	begin
		sckPrev_d = serialClockIn;
		selPrev_d = deviceSelect;
		clockRise = serialClockIn & ~sckPrev_q;
		clockFall = ~serialClockIn & sckPrev_q;
		selectFall = ~deviceSelect & selPrev_q;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sckPrev_q <= 1'b0;
			selPrev_q <= 1'b0;
		end
		else
		begin
			sckPrev_q <= sckPrev_d;
			selPrev_q <= selPrev_d;
		end
	end

endmodule

// File: program_timer.sv
/*
 Self-timed program/erase cycle counter.
 Runs on the core clock alone; start is a one-cycle pulse ignored while busy.
*/
`timescale 1ns/1ps
module program_timer #(
	parameter int CYCLES = eeprom_pkg::PROG_CYCLES
) (
	// Core
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic start,
	output logic busy,
	output logic done
);

	logic [31:0] remain_q;
	logic [31:0] remain_d;

	always_comb
	begin
		remain_d = remain_q;
		done = 1'b0;
		busy = (remain_q != 32'h0);
		if (busy)
		begin
			remain_d = remain_q - 32'h1;
			done = (remain_q == 32'h1);
		end
		else if (start)
			remain_d = 32'(CYCLES);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			remain_q <= 32'h0;
		else
			remain_q <= remain_d;
	end

endmodule

// File: serial_eeprom_program_erase.sv
/*
 Serial EEPROM core: instruction shifter, read-out, ready/busy status,
 permission latch and self-timed write, erase, clear-all and write-all.
 Assumes pins synchronous to a 10 MHz clock; serialOut/serialOutEn are
 resolved onto the data wire outside.
*/
`timescale 1ns/1ps
module serial_eeprom_program_erase #(
	parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
	// Core
	input wire logic clock,
	input wire logic rst_n,
	// Serial link
	input wire logic deviceSelect,
	input wire logic serialClockIn,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	// Organisation: high selects 16-bit words
	input wire logic wordWidthSelect
);

	function automatic logic [5:0] wordIndex(input logic [6:0] a, input logic byteMode);
		wordIndex = byteMode ? a[6:1] : a[5:0];
	endfunction

	function automatic logic [1:0] topBits(input logic [6:0] a, input logic byteMode);
		topBits = byteMode ? a[6:5] : a[5:4];
	endfunction

	// Word or byte placed at the top of a 16-bit shift word
	function automatic logic [15:0] leftAlign(input logic [15:0] w, input logic byteMode,
		input logic lowBit);
		if (!byteMode)
			leftAlign = w;
		else if (lowBit)
			leftAlign = {w[15:8], 8'h00};
		else
			leftAlign = {w[7:0], 8'h00};
	endfunction

	function automatic logic [6:0] nextAddr(input logic [6:0] a, input logic byteMode);
		nextAddr = byteMode ? a + 7'h01 : {1'b0, a[5:0] + 6'h01};
	endfunction

	logic byteMode;
	logic clockRise;
	logic clockFall;
	logic selectFall;
	logic progStart;
	logic progBusy;
	logic progDone;

	eeprom_pkg::state_e state_q;
	eeprom_pkg::state_e state_d;
	eeprom_pkg::pend_e pend_q;
	eeprom_pkg::pend_e pend_d;
	logic [4:0] bitCnt_q;
	logic [4:0] bitCnt_d;
	logic [1:0] opcode_q;
	logic [1:0] opcode_d;
	logic [6:0] addr_q;
	logic [6:0] addr_d;
	logic [15:0] data_q;
	logic [15:0] data_d;
	logic [15:0] rdWord_q;
	logic [15:0] rdWord_d;
	logic permit_q;
	logic permit_d;
	logic hzPend_q;
	logic hzPend_d;
	logic serialOut_q;
	logic serialOut_d;
	logic serialOutEn_q;
	logic serialOutEn_d;
	logic [15:0] mem_q [eeprom_pkg::WORDS];
	logic [15:0] mem_d [eeprom_pkg::WORDS];

	assign byteMode = ~wordWidthSelect;
	assign serialOut = serialOut_q;
	assign serialOutEn = serialOutEn_q;

	serial_pin_edges u_edges (
		.clock(clock),
		.rst_n(rst_n),
		.serialClockIn(serialClockIn),
		.deviceSelect(deviceSelect),
		.clockRise(clockRise),
		.clockFall(clockFall),
		.selectFall(selectFall)
	);

	program_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.start(progStart),
		.busy(progBusy),
		.done(progDone)
	);

	// Instruction sequencing
	always_comb
	begin
		logic [6:0] addrNew;
		logic [15:0] fetched;
		addrNew = {addr_q[5:0], serialIn};
		fetched = 16'h0000;
		state_d = state_q;
		pend_d = pend_q;
		bitCnt_d = bitCnt_q;
		opcode_d = opcode_q;
		addr_d = addr_q;
		data_d = data_q;
		rdWord_d = rdWord_q;
		permit_d = permit_q;
		hzPend_d = hzPend_q;
		serialOut_d = serialOut_q;
		serialOutEn_d = serialOutEn_q;
		progStart = 1'b0;
		if (hzPend_q && clockFall)
		begin
			serialOutEn_d = 1'b0;
			hzPend_d = 1'b0;
		end
		case (state_q)
			eeprom_pkg::ST_IDLE:
			begin
				if (deviceSelect && clockRise && serialIn)
				begin
					state_d = eeprom_pkg::ST_OPCODE;
					bitCnt_d = eeprom_pkg::OPCODE_BITS;
					if (serialOutEn_q && serialOut_q)
						hzPend_d = 1'b1;
				end
			end
			eeprom_pkg::ST_OPCODE:
			begin
				if (clockRise)
				begin
					opcode_d = {opcode_q[0], serialIn};
					bitCnt_d = bitCnt_q - 5'h01;
					if (bitCnt_q == 5'h01)
					begin
						state_d = eeprom_pkg::ST_ADDR;
						bitCnt_d = byteMode ? eeprom_pkg::ADDR_BITS_X8 : eeprom_pkg::ADDR_BITS_X16;
					end
				end
			end
			eeprom_pkg::ST_ADDR:
			begin
				if (clockRise)
				begin
					addr_d = addrNew;
					bitCnt_d = bitCnt_q - 5'h01;
					if (bitCnt_q == 5'h01)
					begin
						case (opcode_q)
							eeprom_pkg::OP_READ:
							begin
								fetched = mem_q[wordIndex(addrNew, byteMode)];
								rdWord_d = leftAlign(fetched, byteMode, addrNew[0]);
								bitCnt_d = byteMode ? eeprom_pkg::DATA_BITS_X8 : eeprom_pkg::DATA_BITS_X16;
								serialOut_d = 1'b0;
								serialOutEn_d = 1'b1;
								hzPend_d = 1'b0;
								state_d = eeprom_pkg::ST_READ;
							end
							eeprom_pkg::OP_ERASE:
							begin
								pend_d = eeprom_pkg::PEND_ERASE;
								state_d = eeprom_pkg::ST_ARMED;
							end
							eeprom_pkg::OP_WRITE:
							begin
								pend_d = eeprom_pkg::PEND_WRITE;
								bitCnt_d = byteMode ? eeprom_pkg::DATA_BITS_X8 : eeprom_pkg::DATA_BITS_X16;
								state_d = eeprom_pkg::ST_DATA;
							end
							default:
							begin
								case (topBits(addrNew, byteMode))
									eeprom_pkg::SUB_ENABLE:
									begin
										permit_d = 1'b1;
										state_d = eeprom_pkg::ST_SKIP;
									end
									eeprom_pkg::SUB_DISABLE:
									begin
										permit_d = 1'b0;
										state_d = eeprom_pkg::ST_SKIP;
									end
									eeprom_pkg::SUB_CLEAR_ALL:
									begin
										pend_d = eeprom_pkg::PEND_CLEAR_ALL;
										state_d = eeprom_pkg::ST_ARMED;
									end
									default:
									begin
										pend_d = eeprom_pkg::PEND_WRITE_ALL;
										bitCnt_d = byteMode ? eeprom_pkg::DATA_BITS_X8 :
											eeprom_pkg::DATA_BITS_X16;
										state_d = eeprom_pkg::ST_DATA;
									end
								endcase
							end
						endcase
					end
				end
			end
			eeprom_pkg::ST_DATA:
			begin
				if (clockRise)
				begin
					data_d = {data_q[14:0], serialIn};
					bitCnt_d = bitCnt_q - 5'h01;
					if (bitCnt_q == 5'h01)
						state_d = eeprom_pkg::ST_ARMED;
				end
			end
			eeprom_pkg::ST_ARMED:
			begin
				if (clockRise)
					state_d = eeprom_pkg::ST_SKIP;
			end
			eeprom_pkg::ST_READ:
			begin
				if (clockRise)
				begin
					if (bitCnt_q == 5'h00)
					begin
						addr_d = nextAddr(addr_q, byteMode);
						fetched = mem_q[wordIndex(addr_d, byteMode)];
						rdWord_d = leftAlign(fetched, byteMode, addr_d[0]);
						serialOut_d = rdWord_d[15];
						rdWord_d = {rdWord_d[14:0], 1'b0};
						bitCnt_d = (byteMode ? eeprom_pkg::DATA_BITS_X8 :
							eeprom_pkg::DATA_BITS_X16) - 5'h01;
					end
					else
					begin
						serialOut_d = rdWord_q[15];
						rdWord_d = {rdWord_q[14:0], 1'b0};
						bitCnt_d = bitCnt_q - 5'h01;
					end
				end
			end
			eeprom_pkg::ST_BUSY:
			begin
				serialOut_d = 1'b0;
				serialOutEn_d = deviceSelect;
				if (progDone)
				begin
					serialOut_d = 1'b1;
					state_d = eeprom_pkg::ST_IDLE;
				end
			end
			eeprom_pkg::ST_SKIP:
			begin
				state_d = eeprom_pkg::ST_SKIP;
			end
			default:
			begin
				state_d = eeprom_pkg::ST_IDLE;
			end
		endcase
		if (selectFall && state_q != eeprom_pkg::ST_BUSY)
		begin
			state_d = eeprom_pkg::ST_IDLE;
			serialOutEn_d = 1'b0;
			hzPend_d = 1'b0;
			if (state_q == eeprom_pkg::ST_ARMED && !clockRise && permit_q)
			begin
				progStart = 1'b1;
				state_d = eeprom_pkg::ST_BUSY;
			end
		end
		else if (!deviceSelect && state_q == eeprom_pkg::ST_IDLE)
			serialOutEn_d = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= eeprom_pkg::ST_IDLE;
			pend_q <= eeprom_pkg::PEND_WRITE;
			bitCnt_q <= 5'h00;
			opcode_q <= 2'h0;
			addr_q <= 7'h00;
			data_q <= 16'h0000;
			rdWord_q <= 16'h0000;
			permit_q <= eeprom_pkg::PERMIT_RESET;
			hzPend_q <= 1'b0;
			serialOut_q <= 1'b0;
			serialOutEn_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			pend_q <= pend_d;
			bitCnt_q <= bitCnt_d;
			opcode_q <= opcode_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdWord_q <= rdWord_d;
			permit_q <= permit_d;
			hzPend_q <= hzPend_d;
			serialOut_q <= serialOut_d;
			serialOutEn_q <= serialOutEn_d;
		end
	end

	// Array: clear at cycle start except for write-all, store at cycle end
	always_comb
	begin
		logic [5:0] idx;
		idx = wordIndex(addr_q, byteMode);
		mem_d = mem_q;
		if (progStart)
		begin
			case (pend_q)
				eeprom_pkg::PEND_WRITE, eeprom_pkg::PEND_ERASE:
				begin
					if (!byteMode)
						mem_d[idx] = eeprom_pkg::ERASED_WORD;
					else if (addr_q[0])
						mem_d[idx][15:8] = eeprom_pkg::ERASED_BYTE;
					else
						mem_d[idx][7:0] = eeprom_pkg::ERASED_BYTE;
				end
				eeprom_pkg::PEND_CLEAR_ALL:
				begin
					for (int i = 0; i < eeprom_pkg::WORDS; i++)
						mem_d[i] = eeprom_pkg::ERASED_WORD;
				end
				default:
				begin
					mem_d = mem_q;
				end
			endcase
		end
		if (progDone)
		begin
			if (pend_q == eeprom_pkg::PEND_WRITE)
			begin
				if (!byteMode)
					mem_d[idx] = data_q;
				else if (addr_q[0])
					mem_d[idx][15:8] = data_q[7:0];
				else
					mem_d[idx][7:0] = data_q[7:0];
			end
			else if (pend_q == eeprom_pkg::PEND_WRITE_ALL)
			begin
				for (int i = 0; i < eeprom_pkg::WORDS; i++)
					mem_d[i] = byteMode ? {data_q[7:0], data_q[7:0]} : data_q;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < eeprom_pkg::WORDS; i++)
				mem_q[i] <= eeprom_pkg::ERASED_WORD;
		end
		else
			mem_q <= mem_d;
	end

endmodule

// File: eeprom_checker_assertions.sv
/*
 Port-level checks of the serial EEPROM core's data-out driver and status.
 Assumes one core clock and the async active-low reset of the core.
*/
`timescale 1ns/1ps
module eeprom_checker #(
	parameter int PROG_CYCLES = 200
) (
	// Core
	input wire logic clock,
	input wire logic rst_n,
	// Serial link
	input wire logic deviceSelect,
	input wire logic serialClockIn,
	input wire logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic wordWidthSelect
);
	localparam int MAXWAIT = PROG_CYCLES + 4;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_idle_quiet: assert property (!deviceSelect |=> !serialOutEn)
		else $error("data out driven while deselected");
	a_drive_cause: assert property ($rose(serialOutEn) |-> $past(deviceSelect))
		else $error("data out driven without select");
	a_release_cause: assert property ($fell(serialOutEn) |->
		!$past(deviceSelect) || ($past(serialClockIn, 2) && !$past(serialClockIn)))
		else $error("data out released without deselect or clock fall");
	a_status_busy: assert property ($rose(serialOutEn) && !$past(deviceSelect, 2) |->
		!serialOut)
		else $error("polled status not low while busy");
	a_ready_bound: assert property ($rose(serialOutEn) && !$past(deviceSelect, 2) |->
		##[0:MAXWAIT] (serialOut || !deviceSelect))
		else $error("timed cycle did not finish in time");
	a_ready_hold: assert property (serialOutEn && serialOut && deviceSelect &&
		!serialClockIn && $stable(serialClockIn) |=> serialOut || !serialOutEn)
		else $error("ready status dropped");
	a_shift_rise: assert property (serialOutEn && $past(serialOutEn) && !serialOut &&
		$past(serialOut) |-> $past(serialClockIn) && !$past(serialClockIn, 2))
		else $error("data out fell without a clock rise");
	a_drive_hold: assert property (serialOutEn && deviceSelect &&
		!$fell(serialClockIn) |=> serialOutEn)
		else $error("data out released while selected");
endmodule

bind serial_eeprom_program_erase eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.clock(clock),
	.rst_n(rst_n),
	.deviceSelect(deviceSelect),
	.serialClockIn(serialClockIn),
	.serialIn(serialIn),
	.serialOut(serialOut),
	.serialOutEn(serialOutEn),
	.wordWidthSelect(wordWidthSelect)
);

// File: eeprom_host_model.sv
/*
 Host side of the serial link: select, serial clock and data in.
 Assumes calls start right after a core clock rising edge.
*/
`timescale 1ns/1ps
module eeprom_host_model (
	// Core
	input wire logic clock,
	// Serial link
	output logic deviceSelect,
	output logic serialClockIn,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	initial
	begin
		deviceSelect = 1'b0;
		serialClockIn = 1'b0;
		serialIn = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic bitOut(input logic b);
		serialIn <= b;
		cyc(2);
		serialClockIn <= 1'b1;
		cyc(3);
		serialClockIn <= 1'b0;
		cyc(2);
	endtask
	task automatic shift(input logic [25:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			bitOut(v[i]);
	endtask
	// Released data line shows the inverse, never the last bit
	task automatic deselect();
		deviceSelect <= 1'b0;
		serialIn <= ~serialIn;
		cyc(3);
	endtask
	task automatic send(input logic [25:0] v, input int n);
		deviceSelect <= 1'b1;
		cyc(2);
		shift(v, n);
		deselect();
	endtask
	// Read instruction of n bits, then nData bits taken after each rise
	task automatic readBits(input logic [25:0] v, input int n, input int nData,
		output logic [15:0] d);
		deviceSelect <= 1'b1;
		cyc(2);
		shift(v, n);
		d = 16'h0000;
		for (int i = 0; i < nData; i++)
		begin
			serialClockIn <= 1'b1;
			cyc(3);
			d = {d[14:0], serialOut};
			serialClockIn <= 1'b0;
			cyc(2);
		end
		deselect();
	endtask
	task automatic readWord(input logic [5:0] a, output logic [15:0] d);
		readBits({17'h0, 3'h6, a}, 9, 16, d);
	endtask
	// Poll status, then release data out with a dummy one
	task automatic poll(output logic busy, output int waited, output logic heldOn);
		deviceSelect <= 1'b1;
		cyc(3);
		busy = serialOutEn === 1'b1 && serialOut === 1'b0;
		waited = 0;
		while (serialOutEn === 1'b1 && serialOut !== 1'b1 && waited < 400)
		begin
			cyc(1);
			waited++;
		end
		heldOn = 1'b0;
		if (busy)
		begin
			bitOut(1'b1);
			cyc(1);
			heldOn = serialOutEn;
		end
		deselect();
	endtask
endmodule

// File: serial_eeprom_program_erase_test.sv
/*
 Self-checking bench of the serial EEPROM core in 16-bit and 8-bit organisation.
 Assumes the host model drives the link and a shortened timed cycle.
*/
`timescale 1ns/1ps
module serial_eeprom_program_erase_test;
	localparam int PROG = 200;
	localparam int LIMIT = 40000;
	logic clock;
	logic rst_n;
	logic deviceSelect;
	logic serialClockIn;
	logic serialIn;
	logic serialOut;
	logic serialOutEn;
	logic wordWidth;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	logic busy;
	logic heldOn;
	int waited;
	logic [15:0] word;

	serial_eeprom_program_erase #(.PROG_CYCLES(PROG)) DUT (
		.clock(clock), .rst_n(rst_n), .deviceSelect(deviceSelect),
		.serialClockIn(serialClockIn), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .wordWidthSelect(wordWidth)
	);
	eeprom_host_model host (
		.clock(clock), .deviceSelect(deviceSelect), .serialClockIn(serialClockIn),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn)
	);
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic expectWord(input logic [5:0] a, input logic [15:0] exp);
		host.readWord(a, word);
		check($sformatf("word %0d", a), exp, word);
	endtask
	task automatic special(input logic [1:0] sub);
		host.send({17'h0, 3'h4, sub, 4'h0}, 9);
	endtask
	task automatic wrWord(input logic [5:0] a, input logic [15:0] d);
		host.send({1'h0, 3'h5, a, d}, 25);
	endtask
	task automatic cycleRan(input logic exp);
		host.poll(busy, waited, heldOn);
		check("busy", {15'h0, exp}, {15'h0, busy});
		check("wait", 16'h1, {15'h0, waited <= PROG});
		check("held", 16'h0, {15'h0, heldOn});
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic t_protect();
		wrWord(6'h05, 16'h1234);
		cycleRan(1'b0);
		special(2'h2);
		cycleRan(1'b0);
		expectWord(6'h05, 16'hFFFF);
		done("protect");
	endtask
	task automatic t_write();
		special(2'h3);
		wrWord(6'h05, 16'hA5C3);
		cycleRan(1'b1);
		expectWord(6'h05, 16'hA5C3);
		wrWord(6'h05, 16'h0F0F);
		cycleRan(1'b1);
		expectWord(6'h05, 16'h0F0F);
		wrWord(6'h06, 16'h1111);
		cycleRan(1'b1);
		done("write");
	endtask
	task automatic t_erase();
		host.send({17'h0, 3'h7, 6'h05}, 9);
		cycleRan(1'b1);
		expectWord(6'h05, 16'hFFFF);
		expectWord(6'h06, 16'h1111);
		done("erase");
	endtask
	task automatic t_all();
		host.send({1'h0, 3'h4, 2'h1, 4'h0, 16'h3C5A}, 25);
		cycleRan(1'b1);
		expectWord(6'h06, 16'h3C5A);
		expectWord(6'h3F, 16'h3C5A);
		special(2'h2);
		cycleRan(1'b1);
		expectWord(6'h3F, 16'hFFFF);
		done("all");
	endtask
	task automatic t_abort();
		host.send({1'h0, 3'h5, 6'h07, 16'hBEEF} >> 1, 24);
		cycleRan(1'b0);
		host.send({3'h5, 6'h07, 16'hBEEF, 1'h0}, 26);
		cycleRan(1'b0);
		expectWord(6'h07, 16'hFFFF);
		done("abort");
	endtask
	task automatic t_busy();
		wrWord(6'h08, 16'h1357);
		host.send({17'h0, 3'h7, 6'h08}, 9);
		cycleRan(1'b1);
		expectWord(6'h08, 16'h1357);
		done("busy");
	endtask
	task automatic t_disable();
		special(2'h0);
		wrWord(6'h08, 16'h7777);
		cycleRan(1'b0);
		host.send({17'h0, 3'h7, 6'h08}, 9);
		cycleRan(1'b0);
		host.send({1'h0, 3'h4, 2'h1, 4'h0, 16'h0000}, 25);
		cycleRan(1'b0);
		expectWord(6'h08, 16'h1357);
		done("disable");
	endtask
	// Byte organisation: byte 0x11 is the high half of word 8
	task automatic t_bytes();
		wordWidth <= 1'b0;
		host.send({16'h0, 3'h4, 2'h3, 5'h00}, 10);
		host.send({8'h0, 3'h5, 7'h11, 8'h9C}, 18);
		cycleRan(1'b1);
		host.readBits({16'h0, 3'h6, 7'h11}, 10, 8, word);
		check("high byte", 16'h009C, word);
		host.send({16'h0, 3'h7, 7'h10}, 10);
		cycleRan(1'b1);
		wordWidth <= 1'b1;
		expectWord(6'h08, 16'h9CFF);
		done("bytes");
	endtask
	initial
	begin
		wordWidth = 1'b1;
		rst_n = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_protect();
		t_write();
		t_erase();
		t_all();
		t_abort();
		t_busy();
		t_disable();
		t_bytes();
		summarize();
	end
endmodule
